// ===== src/parallel_port_pkg.sv
// Constants and types shared by the parallel host port
package parallel_port_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BB_STROBE_NS  = 20;
  // Least strobe width, rounded up to whole cycles
  localparam int BB_STROBE_CYC = (BB_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] STROBE_LOAD = 2'(BB_STROBE_CYC);
  localparam logic [1:0] STROBE_IDLE = 2'h0;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LEVEL_W    = 5;
  localparam logic [7:0] BUS_RESET = 8'h00;
  localparam logic [7:0] OE_NONE   = 8'h00;
  localparam logic [7:0] OE_ALL    = 8'hFF;

  // ----------------------------------------------------------------
  // Port modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_ASYNC,
    MODE_BITBANG
  } mode_t;
endpackage

// ===== src/parallel_port.sv
// Parallel host port: strobe-paced FIFO mode and bit-bang mode, with its byte FIFO
// Behaviour
// - In FIFO mode the data lines are inputs and are driven only while the read strobe is low.
// - The receive-available flag is low while a received byte waits and high otherwise.
// - After each read strobe rises the receive-available flag goes high before it may fall again.
// - The transmit-space flag is low while a byte can be taken and high otherwise.
// - A falling read strobe puts the head byte of the receive FIFO onto the data lines.
// - A rising read strobe advances the receive FIFO to its next byte.
// - A falling write strobe stores the data lines into the transmit FIFO.
// - FIFO mode is used only when the stored configuration selects it.
// - During reset both flag outputs are released rather than driven.
// - A low pulse on the flush/wakeup input while suspended and wakeup-enabled requests a resume.
// - A low pulse on the flush/wakeup input during normal operation requests an immediate flush.
// - In bit-bang mode the eight lines form one bidirectional bus under host control.
// - Bit-bang mode is entered by a host command, not by stored configuration.
// - In bit-bang mode a low write-done pulse follows each applied host value.
// - In bit-bang mode the read-done output rises once the lines are sampled and sent on.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Byte FIFO with registered flags
// ------------------------------------------------------------------
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic    [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0]      level, next_level;
  logic             full, next_full, empty, next_empty, push, pop;
  // Handshake flags kept in their own flops so the ports come straight from registers
  logic             in_ready, out_valid;

  always_comb begin
    push        = in_valid_i & ~full;
    pop         = out_ready_i & ~empty;
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_level  = level + (AW+1)'(push) - (AW+1)'(pop);
    next_full   = (next_level == (AW+1)'(DEPTH));
    next_empty  = (next_level == '0);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
      full      <= 1'b0;
      empty     <= 1'b1;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      level     <= next_level;
      full      <= next_full;
      empty     <= next_empty;
      in_ready  <= ~next_full;
      out_valid <= ~next_empty;
    end
  end

  // Storage is not reset; the flags guard every read of it
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o  = in_ready;
  assign out_valid_o = out_valid;
  assign out_data_o  = mem[rd_ptr];
  assign level_o     = level;
endmodule // byte_fifo

// ------------------------------------------------------------------
// Port top
// ------------------------------------------------------------------
module parallel_port (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       cfg_async_fifo_i,
  input  wire logic       bitbang_cmd_i,
  input  wire logic       bitbang_enable_i,
  input  wire logic       remote_wakeup_en_i,
  input  wire logic       bus_power_active_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       flush_wakeup_n_i,
  input  wire logic [7:0] port_data_lines_i,
  output logic      [7:0] port_data_lines_o,
  output logic      [7:0] port_data_lines_oe_o,
  output logic            rx_available_n_o,
  output logic            rx_available_oe_o,
  output logic            tx_space_n_o,
  output logic            tx_space_oe_o,
  output logic            bitbang_write_done_n_o,
  output logic            bitbang_read_done_n_o,
  input  wire logic       usb_rx_valid_i,
  output logic            usb_rx_ready_o,
  input  wire logic [7:0] usb_rx_data_i,
  output logic            usb_tx_valid_o,
  input  wire logic       usb_tx_ready_i,
  output logic      [7:0] usb_tx_data_o,
  input  wire logic       bb_apply_i,
  input  wire logic [7:0] bb_apply_data_i,
  input  wire logic [7:0] bb_apply_dir_i,
  input  wire logic       bb_sample_i,
  output logic            bb_sample_valid_o,
  output logic      [7:0] bb_sample_data_o,
  output logic            resume_req_o,
  output logic            flush_req_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic       rd_s1, rd_s2, rd_d, wr_s1, wr_s2, wr_d, fw_s1, fw_s2, fw_d;
  logic [7:0] dat_s1, dat_s2;
  logic       rd_fall, rd_rise, wr_fall, fw_fall;

  localparam logic [7:0] BUS_RESET_C = parallel_port_pkg::BUS_RESET;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {rd_s1, rd_s2, rd_d} <= 3'h7;
      {wr_s1, wr_s2, wr_d} <= 3'h7;
      {fw_s1, fw_s2, fw_d} <= 3'h7;
      dat_s1               <= BUS_RESET_C;
      dat_s2               <= BUS_RESET_C;
    end else begin
      {rd_s1, rd_s2, rd_d} <= {rd_n_i, rd_s1, rd_s2};
      {wr_s1, wr_s2, wr_d} <= {wr_n_i, wr_s1, wr_s2};
      {fw_s1, fw_s2, fw_d} <= {flush_wakeup_n_i, fw_s1, fw_s2};
      dat_s1               <= port_data_lines_i;
      dat_s2               <= dat_s1;
    end
  end

  assign rd_fall = rd_d & ~rd_s2;
  assign rd_rise = ~rd_d & rd_s2;
  assign wr_fall = wr_d & ~wr_s2;
  assign fw_fall = fw_d & ~fw_s2;

  // ----------------------------------------------------------------
  // Receive and transmit FIFOs
  // ----------------------------------------------------------------
  parallel_port_pkg::mode_t mode, next_mode;
  logic       rx_valid, rx_pop, tx_ready, tx_push, rd_ok, next_rd_ok;
  logic [7:0] rx_head;
  logic [4:0] rx_level, tx_level;
  logic       is_async, is_bb;

  assign is_async = (mode == parallel_port_pkg::MODE_ASYNC);
  assign is_bb    = (mode == parallel_port_pkg::MODE_BITBANG);
  assign rx_pop   = is_async & rd_rise & rd_ok;
  assign tx_push  = is_async & wr_fall & tx_ready;

  byte_fifo #(.WIDTH(parallel_port_pkg::DATA_W), .DEPTH(parallel_port_pkg::FIFO_DEPTH)) u_rx (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .in_valid_i  (usb_rx_valid_i),
    .in_ready_o  (usb_rx_ready_o),
    .in_data_i   (usb_rx_data_i),
    .out_valid_o (rx_valid),
    .out_ready_i (rx_pop),
    .out_data_o  (rx_head),
    .level_o     (rx_level)
  );

  byte_fifo #(.WIDTH(parallel_port_pkg::DATA_W), .DEPTH(parallel_port_pkg::FIFO_DEPTH)) u_tx (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .in_valid_i  (tx_push),
    .in_ready_o  (tx_ready),
    .in_data_i   (dat_s2),
    .out_valid_o (usb_tx_valid_o),
    .out_ready_i (usb_tx_ready_i),
    .out_data_o  (usb_tx_data_o),
    .level_o     (tx_level)
  );

  // ----------------------------------------------------------------
  // Port control
  // ----------------------------------------------------------------
  logic       bb_sel, next_bb_sel, rx_hold, next_rx_hold;
  logic       next_rxf_n, next_txe_n, next_flag_oe, next_wd_n, next_rdd_n;
  logic       sample_pend, next_sample_pend, next_sample_valid, next_resume, next_flush;
  logic [1:0] wd_cnt, next_wd_cnt;
  logic [7:0] bb_dir, next_bb_dir, next_port_out, next_port_oe, next_sample_data;

  always_comb begin
    next_bb_sel = bitbang_cmd_i ? bitbang_enable_i : bb_sel;
    if (next_bb_sel) begin
      next_mode = parallel_port_pkg::MODE_BITBANG;
    end else if (cfg_async_fifo_i) begin
      next_mode = parallel_port_pkg::MODE_ASYNC;
    end else begin
      next_mode = parallel_port_pkg::MODE_IDLE;
    end
    next_rd_ok    = rd_fall ? rx_valid : rd_ok;
    next_port_out = port_data_lines_o;
    if (is_async && rd_fall && rx_valid) begin
      next_port_out = rx_head;
    end else if (is_bb && bb_apply_i) begin
      next_port_out = bb_apply_data_i;
    end
    // host sets the direction of each line
    next_bb_dir = (is_bb && bb_apply_i) ? bb_apply_dir_i : bb_dir;
    // in FIFO mode, drive only while the read strobe is low; in bit-bang mode follow the host direction
    if (is_async) begin
      next_port_oe = (!rd_s2 && next_rd_ok) ? parallel_port_pkg::OE_ALL
                                            : parallel_port_pkg::OE_NONE;
    end else if (is_bb) begin
      next_port_oe = next_bb_dir;
    end else begin
      next_port_oe = parallel_port_pkg::OE_NONE;
    end
    // flag high for two cycles after each rise
    next_rx_hold = rd_rise;
    // flag low while a byte waits
    next_rxf_n   = ~(is_async & rx_valid & ~rx_hold & ~rd_rise);
    // flag low while a byte can be taken
    next_txe_n   = ~(is_async & tx_ready);
    // flags released outside FIFO mode and in reset
    next_flag_oe = is_async;
    if (is_bb && bb_apply_i) begin
      next_wd_cnt = parallel_port_pkg::STROBE_LOAD;
    end else if (wd_cnt != parallel_port_pkg::STROBE_IDLE) begin
      next_wd_cnt = wd_cnt - 2'h1;
    end else begin
      next_wd_cnt = wd_cnt;
    end
    next_wd_n = (wd_cnt == parallel_port_pkg::STROBE_IDLE);
    // read-done rises as the sample leaves
    next_sample_pend  = is_bb & bb_sample_i & ~sample_pend;
    next_rdd_n        = ~next_sample_pend;
    next_sample_valid = sample_pend;
    next_sample_data  = sample_pend ? dat_s2 : bb_sample_data_o;
    next_resume = fw_fall & bus_power_active_n_i & remote_wakeup_en_i;
    next_flush  = fw_fall & ~bus_power_active_n_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mode                   <= parallel_port_pkg::MODE_IDLE;
      bb_sel                 <= 1'b0;
      rd_ok                  <= 1'b0;
      rx_hold                <= 1'b0;
      bb_dir                 <= parallel_port_pkg::OE_NONE;
      port_data_lines_o      <= parallel_port_pkg::BUS_RESET;
      port_data_lines_oe_o   <= parallel_port_pkg::OE_NONE;
      rx_available_n_o       <= 1'b1;
      tx_space_n_o           <= 1'b1;
      rx_available_oe_o      <= 1'b0;
      tx_space_oe_o          <= 1'b0;
      wd_cnt                 <= parallel_port_pkg::STROBE_IDLE;
      bitbang_write_done_n_o <= 1'b1;
      sample_pend            <= 1'b0;
      bitbang_read_done_n_o  <= 1'b1;
      bb_sample_valid_o      <= 1'b0;
      bb_sample_data_o       <= parallel_port_pkg::BUS_RESET;
      resume_req_o           <= 1'b0;
      flush_req_o            <= 1'b0;
    end else begin
      mode                   <= next_mode;
      bb_sel                 <= next_bb_sel;
      rd_ok                  <= next_rd_ok;
      rx_hold                <= next_rx_hold;
      bb_dir                 <= next_bb_dir;
      port_data_lines_o      <= next_port_out;
      port_data_lines_oe_o   <= next_port_oe;
      rx_available_n_o       <= next_rxf_n;
      tx_space_n_o           <= next_txe_n;
      rx_available_oe_o      <= next_flag_oe;
      tx_space_oe_o          <= next_flag_oe;
      wd_cnt                 <= next_wd_cnt;
      bitbang_write_done_n_o <= next_wd_n;
      sample_pend            <= next_sample_pend;
      bitbang_read_done_n_o  <= next_rdd_n;
      bb_sample_valid_o      <= next_sample_valid;
      bb_sample_data_o       <= next_sample_data;
      resume_req_o           <= next_resume;
      flush_req_o            <= next_flush;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_bus_released;
    is_async && rd_s2 |=> port_data_lines_oe_o == parallel_port_pkg::OE_NONE;
  endproperty
  a_bus_released: assert property (p_bus_released) else $error("bus driven with read high");

  property p_rxf_low;
    is_async && rx_valid && !rx_hold && !rd_rise |=> !rx_available_n_o;
  endproperty
  a_rxf_low: assert property (p_rxf_low) else $error("flag high with byte waiting");

  property p_rxf_after_read;
    rd_rise |=> rx_available_n_o [*2];
  endproperty
  a_rxf_after_read: assert property (p_rxf_after_read) else $error("flag not forced high");

  property p_txe_state;
    !tx_space_n_o |-> $past(tx_ready) && $past(is_async);
  endproperty
  a_txe_state: assert property (p_txe_state) else $error("space flag low while full");

  property p_head_out;
    is_async && rd_fall && rx_valid |=> port_data_lines_o == $past(rx_head);
  endproperty
  a_head_out: assert property (p_head_out) else $error("head byte not presented");

  property p_rx_advance;
    rx_pop && !(usb_rx_valid_i && usb_rx_ready_o) |=> rx_level == $past(rx_level) - 5'h1;
  endproperty
  a_rx_advance: assert property (p_rx_advance) else $error("receive FIFO not advanced");

  property p_tx_capture;
    is_async && wr_fall && tx_ready && !(usb_tx_valid_o && usb_tx_ready_i)
      |=> tx_level == $past(tx_level) + 5'h1;
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("write not captured");

  property p_flags_released;
    @(posedge clk_sys_i) disable iff (1'b0) srst_i |=> !rx_available_oe_o && !tx_space_oe_o;
  endproperty
  a_flags_released: assert property (p_flags_released) else $error("flag driven in reset");

  property p_resume;
    fw_fall && bus_power_active_n_i && remote_wakeup_en_i |=> resume_req_o && !flush_req_o;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not requested");

  property p_flush;
    fw_fall && !bus_power_active_n_i |=> flush_req_o && !resume_req_o;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not requested");

  property p_write_done;
    is_bb && bb_apply_i |=> ##1 !bitbang_write_done_n_o [*2] ##1 bitbang_write_done_n_o;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write-done pulse wrong");

  property p_read_done;
    is_bb && bb_sample_i && !sample_pend |=> !bitbang_read_done_n_o
      ##1 (bitbang_read_done_n_o && bb_sample_valid_o);
  endproperty
  a_read_done: assert property (p_read_done) else $error("read-done edge wrong");

  property p_no_underflow;
    is_async && rd_fall && !rx_valid |=> !rd_ok [*3];
  endproperty
  a_no_underflow: assert property (p_no_underflow) else $error("empty read advanced");

  c_async_read:  cover property (rx_pop ##[1:8] !rx_available_n_o);
  c_async_write: cover property (tx_push && tx_level == 5'h0f);
  c_bb_write:    cover property (is_bb && bb_apply_i ##3 !bitbang_write_done_n_o);
  c_wakeup:      cover property (resume_req_o);
endmodule // parallel_port

`default_nettype wire

// ===== bench/strobe_host_model.sv
// Behavioural external controller on the strobe bus
`timescale 1ns/1ps
`default_nettype none
module strobe_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic [7:0] dev_oe_i,
  input  wire logic       rx_flag_i,
  input  wire logic       rx_oe_i,
  input  wire logic       tx_flag_i,
  input  wire logic       tx_oe_i,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            flush_n_o,
  output logic      [7:0] lines_o
);
  logic [7:0] host_d = 8'h00;
  logic       host_oe = 1'b0;
  logic [7:0] last = 8'h00;
  logic       rx_seen;
  logic       tx_seen;
  // ----------------------------------------------------------------
  // Wire levels
  // ----------------------------------------------------------------
  // Released flags float to their pull-up
  assign rx_seen = rx_oe_i ? rx_flag_i : 1'b1;
  assign tx_seen = tx_oe_i ? tx_flag_i : 1'b1;
  // Undriven bits show the inverse of the last level, so no stale byte passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lines_o[i] = dev_oe_i[i] ? dev_data_i[i] : (host_oe ? host_d[i] : ~last[i]);
    end
  end
  always @(posedge clk_sys_i) begin
    last <= lines_o;
  end
  initial begin
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    flush_n_o = 1'b1;
  end
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // read only on low flag unless told to misbehave
  task automatic read_byte(input bit ign, output logic [7:0] d, output logic [7:0] oe,
                           output logic fl);
    int n;
    n = 0;
    while (!ign && rx_seen !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    rd_n_o = 1'b0;
    tick(6);
    d = lines_o;
    oe = dev_oe_i;
    rd_n_o = 1'b1;
    tick(4);
    fl = rx_seen;
    tick(2);
  endtask
  // write only on low flag, strobe low then high
  task automatic write_byte(input bit ign, input logic [7:0] d);
    int n;
    n = 0;
    while (!ign && tx_seen !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    host_d = d;
    host_oe = 1'b1;
    tick(4);
    wr_n_o = 1'b0;
    tick(4);
    wr_n_o = 1'b1;
    tick(1);
    host_oe = 1'b0;
    tick(3);
  endtask
  task automatic drive_lines(input logic [7:0] d, input logic en);
    host_d = d;
    host_oe = en;
  endtask
  task automatic pulse_flush();
    flush_n_o = 1'b0;
    tick(4);
    flush_n_o = 1'b1;
    tick(1);
  endtask
endmodule // strobe_host_model
`default_nettype wire

// ===== bench/test_async_fifo_bitbang_port.sv
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_async_fifo_bitbang_port;
  logic       clk_sys_i = 1'b0;
  logic       srst_i, cfg_async_fifo_i, bitbang_cmd_i, bitbang_enable_i;
  logic       remote_wakeup_en_i, bus_power_active_n_i, rd_n, wr_n, flush_n;
  logic       rx_available_n_o, rx_available_oe_o, tx_space_n_o, tx_space_oe_o;
  logic       bitbang_write_done_n_o, bitbang_read_done_n_o, usb_rx_valid_i, usb_rx_ready_o;
  logic       usb_tx_valid_o, usb_tx_ready_i, bb_apply_i, bb_sample_i, bb_sample_valid_o;
  logic       resume_req_o, flush_req_o;
  logic [7:0] lines, port_data_lines_o, port_data_lines_oe_o, usb_rx_data_i, usb_tx_data_o;
  logic [7:0] bb_apply_data_i, bb_apply_dir_i, bb_sample_data_o;
  int         mismatches = 0;
  int         checks_done = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  parallel_port u_parallel_port (
    .clk_sys_i, .srst_i, .cfg_async_fifo_i, .bitbang_cmd_i, .bitbang_enable_i,
    .remote_wakeup_en_i, .bus_power_active_n_i, .rd_n_i(rd_n), .wr_n_i(wr_n),
    .flush_wakeup_n_i(flush_n), .port_data_lines_i(lines), .port_data_lines_o,
    .port_data_lines_oe_o, .rx_available_n_o, .rx_available_oe_o, .tx_space_n_o,
    .tx_space_oe_o, .bitbang_write_done_n_o, .bitbang_read_done_n_o, .usb_rx_valid_i,
    .usb_rx_ready_o, .usb_rx_data_i, .usb_tx_valid_o, .usb_tx_ready_i, .usb_tx_data_o,
    .bb_apply_i, .bb_apply_data_i, .bb_apply_dir_i, .bb_sample_i, .bb_sample_valid_o,
    .bb_sample_data_o, .resume_req_o, .flush_req_o);

  strobe_host_model u_strobe_host_model (
    .clk_sys_i, .dev_data_i(port_data_lines_o), .dev_oe_i(port_data_lines_oe_o),
    .rx_flag_i(rx_available_n_o), .rx_oe_i(rx_available_oe_o), .tx_flag_i(tx_space_n_o),
    .tx_oe_i(tx_space_oe_o), .rd_n_o(rd_n), .wr_n_o(wr_n), .flush_n_o(flush_n),
    .lines_o(lines));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_rx_path();
    logic [7:0] d;
    logic [7:0] oe;
    logic       fl;
    `CHK(rx_available_n_o, 1'b1)
    usb_rx_valid_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      usb_rx_data_i = 8'hA0 ^ 8'(i);
      tick(1);
    end
    usb_rx_valid_i = 1'b0;
    tick(1);
    `CHK(usb_rx_ready_o, 1'b0) // full
    `CHK(port_data_lines_oe_o, 8'h00)
    for (int i = 0; i < 16; i++) begin
      u_strobe_host_model.read_byte(1'b0, d, oe, fl);
      `CHK(d, 8'hA0 ^ 8'(i))
      `CHK(oe, 8'hFF)
      `CHK(fl, 1'b1)
    end
    `CHK(rx_available_n_o, 1'b1)
    u_strobe_host_model.read_byte(1'b1, d, oe, fl);
    `CHK(oe, 8'h00) // empty
    `CHK(port_data_lines_oe_o, 8'h00)
  endtask

  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (usb_tx_valid_o !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    `CHK(usb_tx_data_o, exp)
    usb_tx_ready_i = 1'b1;
    tick(1);
    usb_tx_ready_i = 1'b0;
    tick(1);
  endtask

  task automatic t_tx_path();
    `CHK(tx_space_n_o, 1'b0)
    for (int i = 0; i < 16; i++) begin
      u_strobe_host_model.write_byte(1'b0, 8'h30 + 8'(i));
    end
    tick(3);
    `CHK(tx_space_n_o, 1'b1)
    u_strobe_host_model.write_byte(1'b1, 8'hEE);
    for (int i = 0; i < 16; i++) begin
      pop(8'h30 + 8'(i));
    end
    tick(2);
    `CHK(usb_tx_valid_o, 1'b0) // dropped
    `CHK(tx_space_n_o, 1'b0)
  endtask

  task automatic t_mode_cfg();
    cfg_async_fifo_i = 1'b0;
    tick(3);
    `CHK({rx_available_oe_o, tx_space_oe_o}, 2'h0)
    u_strobe_host_model.write_byte(1'b1, 8'h77);
    tick(2);
    `CHK(usb_tx_valid_o, 1'b0)
    cfg_async_fifo_i = 1'b1;
    tick(3);
    `CHK({rx_available_oe_o, tx_space_oe_o}, 2'h3)
  endtask

  task automatic t_bitbang();
    bitbang_cmd_i = 1'b1;
    bitbang_enable_i = 1'b1;
    tick(1);
    bitbang_cmd_i = 1'b0;
    tick(2);
    `CHK(rx_available_oe_o, 1'b0)
    `CHK(bitbang_write_done_n_o, 1'b1)
    bb_apply_i = 1'b1;
    bb_apply_data_i = 8'h5A;
    bb_apply_dir_i = 8'hF0;
    tick(1);
    bb_apply_i = 1'b0;
    tick(1);
    `CHK(port_data_lines_oe_o, 8'hF0)
    `CHK(port_data_lines_o[7:4], 4'h5)
    `CHK(bitbang_write_done_n_o, 1'b0)
    tick(1);
    `CHK(bitbang_write_done_n_o, 1'b0)
    tick(1);
    `CHK(bitbang_write_done_n_o, 1'b1)
    u_strobe_host_model.drive_lines(8'h03, 1'b1);
    tick(4);
    bb_sample_i = 1'b1;
    tick(1);
    bb_sample_i = 1'b0;
    `CHK(bitbang_read_done_n_o, 1'b0)
    tick(1);
    `CHK(bitbang_read_done_n_o, 1'b1)
    `CHK(bb_sample_valid_o, 1'b1)
    `CHK(bb_sample_data_o, 8'h53)
    u_strobe_host_model.drive_lines(8'h00, 1'b0);
    bitbang_cmd_i = 1'b1;
    bitbang_enable_i = 1'b0;
    tick(1);
    bitbang_cmd_i = 1'b0;
    tick(3);
    `CHK(rx_available_oe_o, 1'b1)
  endtask

  task automatic t_flush();
    logic       f;
    logic       r;
    logic [3:0] cases [3];
    cases = '{4'b0110, 4'b1101, 4'b1000};
    for (int k = 0; k < 3; k++) begin
      bus_power_active_n_i = cases[k][3];
      remote_wakeup_en_i = cases[k][2];
      f = 1'b0;
      r = 1'b0;
      fork
        u_strobe_host_model.pulse_flush();
        for (int j = 0; j < 12; j++) begin
          tick(1);
          f = f | flush_req_o;
          r = r | resume_req_o;
        end
      join
      `CHK({f, r}, cases[k][1:0])
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    {srst_i, cfg_async_fifo_i} = 2'b11;
    {bitbang_cmd_i, bitbang_enable_i, remote_wakeup_en_i, bus_power_active_n_i} = 4'h0;
    {usb_rx_valid_i, usb_tx_ready_i, bb_apply_i, bb_sample_i} = 4'h0;
    {usb_rx_data_i, bb_apply_data_i, bb_apply_dir_i} = 24'h00_0000;
    tick(5);
    `CHK({rx_available_oe_o, tx_space_oe_o, port_data_lines_oe_o}, 10'h000)
    tick(5);
    srst_i = 1'b0;
    tick(4);
    t_rx_path();
    t_tx_path();
    t_mode_cfg();
    t_bitbang();
    t_flush();
    end_sim();
  end

  // Whole run needs about 550 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    end_sim();
  end
endmodule // test_async_fifo_bitbang_port
`default_nettype wire
